// ### hdl/access_timer.sv
/*
 * access wait counter: counts down from a load value, flags zero.
 * assumes the loader pulses load for one cycle per access.
 */
`timescale 1ns/1ps
module access_timer
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       load,
	input  wire logic [3:0] load_value,
	output logic            expired
);
	import rom_port_pkg::*;
	logic [3:0] count_reg;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			count_reg <= CNT_ZERO;
		else if (load)
			count_reg <= load_value;
		else if (count_reg != CNT_ZERO)
			count_reg <= count_reg - 4'h1;
	end

	// expired must not look at load: the loader reloads on seeing expiry,
	// and gating with load would close a combinational loop
	assign expired = (count_reg == CNT_ZERO);
endmodule

// ### hdl/external_program_rom_port.sv
/*
 * fetch engine for external program memory: drives the code address,
 * reads one wide word or two narrow halves, hands the instruction to
 * the core and marks instruction completion.
 * assumes the core answers exec_done and raises jump_valid with a jump target
 * in the cycle after it; inputs are synchronous to mclk.
 * limitation: a jump request outside that cycle is not seen.
 * narrow mode takes two access waits per word, so fetches run about half as fast.
 */
`timescale 1ns/1ps
module external_program_rom_port
(
	input  wire logic                             mclk,
	input  wire logic                             resetn,
	input  wire logic                             rom_bus_width_select,
	input  wire logic [rom_port_pkg::DATA_W-1:0]  code_data_bus,
	input  wire logic                             hold_n,
	input  wire logic                             jump_valid,
	input  wire logic [rom_port_pkg::ADDR_W-1:0]  jump_addr,
	input  wire logic                             exec_done,
	output logic      [rom_port_pkg::ADDR_W-1:0]  code_address_bus,
	output logic                                  word_half_select,
	output logic                                  even_odd_rom_select,
	output logic                                  instruction_done_strobe,
	output logic      [rom_port_pkg::DATA_W-1:0]  instr_word,
	output logic                                  instr_valid
);
	import rom_port_pkg::*;

	fetch_state_t      state_reg;
	fetch_state_t      state_next;
	logic [ADDR_W-1:0] pc_reg;
	logic [HIGH_W-1:0] high_part_reg;
	logic              wide_reg;
	logic              timer_load;
	logic              timer_expired;
	logic              high_done;
	logic              low_done;

	// ************************************************************
	// decoding helpers
	// ************************************************************
	// a read ends in the cycle its state sees the access wait run out
	function automatic logic read_done
	(
		input fetch_state_t cur,
		input fetch_state_t want,
		input logic         expired
	);
		read_done = (cur == want) && expired;
	endfunction

	// a jump replaces the step to the next word
	function automatic logic [ADDR_W-1:0] follow_addr
	(
		input logic              take_jump,
		input logic [ADDR_W-1:0] target,
		input logic [ADDR_W-1:0] current
	);
		follow_addr = take_jump ? target : current + 15'h0001;
	endfunction

	// the high part sits above the low part in the finished word
	function automatic logic [DATA_W-1:0] join_halves
	(
		input logic [HIGH_W-1:0] upper,
		input logic [LOW_W-1:0]  lower
	);
		join_halves = {upper, lower};
	endfunction

	// half select is high only for the whole of the low read
	function automatic logic low_half_next
	(
		input fetch_state_t nxt
	);
		low_half_next = (nxt == st_low);
	endfunction

	// ************************************************************
	// access timing
	// ************************************************************
	access_timer u_timer
	(
		.mclk       (mclk),
		.resetn     (resetn),
		.load       (timer_load),
		.load_value (ACCESS_CNT),
		.expired    (timer_expired)
	);

	assign high_done  = read_done(state_reg, st_high, timer_expired);
	assign low_done   = read_done(state_reg, st_low, timer_expired);

	// the low read reloads the wait in the same cycle the high read ends
	assign timer_load = (state_reg == st_addr) || (high_done && !wide_reg);

	// ************************************************************
	// sequencing
	// ************************************************************
	// hold_n only parks the engine between instructions; a fetch in flight finishes
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			st_addr:
				if (hold_n)
					state_next = st_high;
			st_high:
				if (timer_expired)
					state_next = wide_reg ? st_exec : st_low;
			st_low:
				if (timer_expired)
					state_next = st_exec;
			st_exec:
				if (exec_done)
					state_next = st_done;
			st_done:
				state_next = st_addr;
			default:
				state_next = st_addr;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			state_reg <= st_addr;
		else
			state_reg <= state_next;
	end

	// the strap is latched per instruction so a change never splits a word
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			wide_reg <= 1'b1;
		else if (state_reg == st_addr)
			wide_reg <= rom_bus_width_select;
	end

	// ************************************************************
	// address and selects
	// ************************************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			pc_reg <= RESET_ADDR;
		else if (state_reg == st_done)
			pc_reg <= follow_addr(jump_valid, jump_addr, pc_reg);
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			code_address_bus <= RESET_ADDR;
		else
			code_address_bus <= pc_reg;
	end

	// words at consecutive addresses alternate between the even and the odd memory
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			even_odd_rom_select <= 1'b0;
		else
			even_odd_rom_select <= pc_reg[EVEN_ODD_BIT];
	end

	// held low in wide mode; memory must not use it then
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			word_half_select <= 1'b0;
		else if (wide_reg)
			word_half_select <= 1'b0;
		else
			word_half_select <= low_half_next(state_next);
	end

	// ************************************************************
	// data capture
	// ************************************************************
	// high part rides on the lowest 5 lines in narrow mode
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			high_part_reg <= 5'h00;
		else if (high_done)
			high_part_reg <= code_data_bus[HIGH_W-1:0];
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			instr_word <= RESET_WORD;
		else if (high_done && wide_reg)
			instr_word <= code_data_bus;
		else if (low_done)
			instr_word <= join_halves(high_part_reg, code_data_bus[LOW_W-1:0]);
	end

	// valid drops in the cycle the strobe rises
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			instr_valid <= 1'b0;
		else
			instr_valid <= (state_next == st_exec);
	end

	// ************************************************************
	// completion
	// ************************************************************
	// one pulse per instruction: st_done always follows, so a long exec_done cannot repeat it
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			instruction_done_strobe <= 1'b0;
		else
			instruction_done_strobe <= (state_reg == st_exec) && exec_done;
	end
endmodule

// ### hdl/rom_port_pkg.sv
/*
 * constants and types for the external program memory fetch port.
 * assumes a single 100 MHz clock and a synchronous active-low reset.
 */
package rom_port_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 13;
	localparam int HIGH_W = 5;
	localparam int LOW_W  = 8;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 15'h0000;
	localparam logic [DATA_W-1:0] RESET_WORD = 13'h0000;
	// cycles the address is held before data is sampled (100 ns access at 10 ns)
	localparam int ACCESS_NS = 100;
	localparam int CLK_NS    = 10;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC - 1);
	localparam logic [3:0] CNT_ZERO   = 4'h0;
	// even/odd memory chosen by the lowest address bit
	localparam int EVEN_ODD_BIT = 0;

	typedef enum logic [2:0] {
		st_addr,
		st_high,
		st_low,
		st_exec,
		st_done
	} fetch_state_t;
endpackage

// ### test/external_program_rom_port_test.sv
/* fetch port bench: table of fetches, then hold and reset by hand.
   assumes the rom model answers combinationally. */
`timescale 1ns/1ps
module external_program_rom_port_test;
	import rom_port_pkg::*;
	typedef struct packed {logic [14:0] a; logic nxt; logic j; logic h;} row_t;
	logic mclk = 0, resetn = 0, strap = 1, hold_n = 1, jv = 0, ed = 0, hs, eo, sb, iv;
	logic [14:0] ca;
	logic [12:0] cd, iw;
	int errors = 0, checks_done = 0, cyc = 0;
	row_t rows [5] = '{'{15'h0000, 0, 0, 1}, '{15'h0001, 1, 0, 1},
		'{15'h0002, 0, 0, 1}, '{15'h0003, 0, 1, 1}, '{15'h5FFF, 0, 0, 0}};
	always #5 mclk = ~mclk;
	rom_model rom (.code_address_bus(ca), .word_half_select(hs),
		.rom_bus_width_select(strap), .code_data_bus(cd));
	external_program_rom_port dut (.mclk(mclk), .resetn(resetn), .rom_bus_width_select(strap),
		.code_data_bus(cd), .hold_n(hold_n), .jump_valid(jv), .jump_addr(15'h5FFF),
		.exec_done(ed), .code_address_bus(ca), .word_half_select(hs),
		.even_odd_rom_select(eo), .instruction_done_strobe(sb), .instr_word(iw),
		.instr_valid(iv));
	task test_done;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin errors++; test_done; end
	end
	task chk(input string n, input logic [14:0] e, input logic [14:0] s);
		checks_done++;
		if (s !== e) begin errors++; $display("Error %s expected %h seen %h", n, e, s); end
	endtask
	task step(input row_t r);
		int n;
		n = 0;
		while (iv !== 1'b1 && n < 60) begin @(negedge mclk); n++; end
		chk("address", r.a, ca);
		chk("even_odd", 15'(r.a[0]), 15'(eo));
		chk("word", 15'({r.a[4:0] ^ 5'h15, r.a[12:5] ^ 8'h3C}), 15'(iw));
		chk("half_select", 15'h0000, 15'(hs));
		strap = r.nxt; jv = r.j; hold_n = r.h; ed = 1;
		@(negedge mclk);
		ed = 0;
		chk("strobe", 15'h0001, 15'(sb));
		@(negedge mclk);
		jv = 0;
	endtask
	initial begin
		repeat (2) @(negedge mclk);
		resetn = 1;
		for (int i = 0; i < 5; i++) step(rows[i]);
		repeat (40) @(negedge mclk);
		chk("held", 15'h0000, 15'(iv));
		chk("held address", 15'h6000, ca);
		hold_n = 1;
		step(row_t'{15'h6000, 1'b1, 1'b0, 1'b1});
		resetn = 0;
		@(negedge mclk);
		chk("reset address", 15'h0000, ca);
		chk("reset strobe", 15'h0000, 15'({sb, iv}));
		resetn = 1;
		step(row_t'{15'h0000, 1'b1, 1'b0, 1'b1});
		test_done;
	end
endmodule

// ### test/rom_model.sv
/* external program memory stand-in.
   assumes it sees the address, the half select and the board strap. */
`timescale 1ns/1ps
module rom_model
(
	input  wire logic [14:0] code_address_bus,
	input  wire logic        word_half_select,
	input  wire logic        rom_bus_width_select,
	output logic      [12:0] code_data_bus
);
	logic [12:0] w;
	// content is a fixed scramble of the lower thirteen address lines
	assign w = {code_address_bus[4:0] ^ 5'h15, code_address_bus[12:5] ^ 8'h3C};
	// unused lines carry the inverse of the other part, so a wrong lane never reads as that part
	assign code_data_bus = rom_bus_width_select ? w :
		(word_half_select ? {~w[12:8], w[7:0]} : {~w[7:0], w[12:8]});
endmodule

// ### test/rom_port_properties.sv
/* fetch port checker.
   assumes it is bound to the top module. */
`timescale 1ns/1ps
module rom_port_check
(
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        rom_bus_width_select,
	input wire logic        exec_done,
	input wire logic [14:0] code_address_bus,
	input wire logic        word_half_select,
	input wire logic        even_odd_rom_select,
	input wire logic        instruction_done_strobe,
	input wire logic        instr_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_eo; even_odd_rom_select == code_address_bus[0]; endproperty
	a_eo: assert property (p_eo) else $error("select mismatch");
	property p_chg; $changed(code_address_bus) |->
		$past(instruction_done_strobe, 1) || $past(instruction_done_strobe, 2); endproperty
	a_chg: assert property (p_chg) else $error("address moved early");
	property p_stab; instr_valid |-> $stable(code_address_bus); endproperty
	a_stab: assert property (p_stab) else $error("address unstable");
	property p_wide; $rose(word_half_select) |-> !rom_bus_width_select; endproperty
	a_wide: assert property (p_wide) else $error("half select in wide mode");
	property p_low; $rose(word_half_select) |=> !instr_valid [*8]; endproperty
	a_low: assert property (p_low) else $error("low read cut short");
	property p_asm; $rose(word_half_select) |-> ##[8:14] $rose(instr_valid); endproperty
	a_asm: assert property (p_asm) else $error("word not assembled");
	property p_pulse; instruction_done_strobe |=> !instruction_done_strobe; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe too long");
	property p_cause; $rose(instruction_done_strobe) |->
		$past(instr_valid) && $past(exec_done); endproperty
	a_cause: assert property (p_cause) else $error("strobe without completion");
	cover property ($rose(word_half_select));
	cover property ($rose(instruction_done_strobe) && code_address_bus[0]);
	cover property (instr_valid && rom_bus_width_select);
endmodule
bind external_program_rom_port rom_port_check chk (.mclk(mclk), .resetn(resetn),
	.rom_bus_width_select(rom_bus_width_select), .exec_done(exec_done),
	.code_address_bus(code_address_bus), .word_half_select(word_half_select),
	.even_odd_rom_select(even_odd_rom_select),
	.instruction_done_strobe(instruction_done_strobe), .instr_valid(instr_valid));
